/* hdl/dmawc_pkg.sv */
package dmawc_pkg;

  // ****************************************
  // Register map (byte offsets on Wishbone)
  // ****************************************
  localparam logic [3:0] ADDR_LOW_MID   = 4'h0;
  localparam logic [3:0] ADDR_MID_HIGH  = 4'h4;
  localparam logic [3:0] ADDR_LOW_CNT   = 4'h8;
  localparam logic [3:0] ADDR_MID_CNT   = 4'hc;

  // Decode slot for the high-area count and the status word
  localparam logic [4:0] ADDR_HIGH_CNT  = 5'h10;
  localparam logic [4:0] ADDR_STATUS    = 5'h14;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         CNT_W          = 3;
  localparam int         BND_W          = 8;
  localparam logic [7:0] BND_RESET      = 8'h00;
  localparam logic [2:0] CNT_RESET      = 3'h7;
  localparam int         ADDR_W         = 24;
  localparam int         BND_LSB        = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    AREA_LOW,
    AREA_MID,
    AREA_HIGH
  } dmawc_area_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_T2,
    BUS_EXT,
    BUS_T3
  } dmawc_state_t;

  // Bus-cycle request from the DMA engine
  typedef struct packed {
    logic              start;
    logic [ADDR_W-1:0] addr;
  } dmawc_req_t;

endpackage

/* hdl/dmawc_ctrl.sv */
// Summary of operation
// - Extension states go only between bus state two and bus state three.
// - Extension comes from the external request line or the area counts.
// - Each of three areas has its own 0..7 extension count.
// - Address space splits into low, middle and high areas by two boundaries.
// - Low-mid boundary gives address bits 23..16; low bits are zero.
// - Mid-high boundary gives address bits 23..16; low bits are zero.
// - Area choice uses only the top eight address bits.
// - A zero boundary means that boundary sits at top; area absent.
// - Both boundary registers are read/write eight bits, reset to zero.
// - Each count field is binary 0..7 and resets to seven.
// - Request line sampled in state two and extension; each high forces one extension, overlapping the count.
// - Register count first, then more while the external line requests.
// - After reset every cycle uses the low-area count.
module dmawc_ctrl #(
  parameter int ADDR_W = dmawc_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [4:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // DMA bus cycle side
  input  wire dmawc_pkg::dmawc_req_t   dmaReq,
  input  wire logic                    cpuModeZero,
  input  wire logic                    extWaitRequest,
  output logic                         inExtensionState,
  output logic                         busStateThree,
  output dmawc_pkg::dmawc_area_t       curArea
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0]                lowMidBoundary_reg;
  logic [7:0]                midHighBoundary_reg;
  logic [2:0]                lowCount_reg;
  logic [2:0]                midCount_reg;
  logic [2:0]                highCount_reg;
  logic                      ack_reg;
  logic [31:0]               rdData_reg;
  logic                      wrStrobe;
  logic                      extSample;

  assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0]; // Lands with ack
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  // Single-wait ack, dropped the cycle after
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  // Boundary and count writes
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lowMidBoundary_reg  <= dmawc_pkg::BND_RESET;
      midHighBoundary_reg <= dmawc_pkg::BND_RESET;
      lowCount_reg        <= dmawc_pkg::CNT_RESET;
      midCount_reg        <= dmawc_pkg::CNT_RESET;
      highCount_reg       <= dmawc_pkg::CNT_RESET;
    end else if (wrStrobe) begin
      unique case (wb_adr_i)
        {1'b0, dmawc_pkg::ADDR_LOW_MID}:  lowMidBoundary_reg  <= wb_dat_i[7:0];
        {1'b0, dmawc_pkg::ADDR_MID_HIGH}: midHighBoundary_reg <= wb_dat_i[7:0];
        {1'b0, dmawc_pkg::ADDR_LOW_CNT}:  lowCount_reg  <= wb_dat_i[2:0];
        {1'b0, dmawc_pkg::ADDR_MID_CNT}:  midCount_reg  <= wb_dat_i[2:0];
        dmawc_pkg::ADDR_HIGH_CNT:         highCount_reg <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // Read data; unmapped reads zero
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdData_reg <= 32'h0000_0000;
    end else begin
      unique case (wb_adr_i)
        {1'b0, dmawc_pkg::ADDR_LOW_MID}:  rdData_reg <= {24'h000000, lowMidBoundary_reg};
        {1'b0, dmawc_pkg::ADDR_MID_HIGH}: rdData_reg <= {24'h000000, midHighBoundary_reg};
        {1'b0, dmawc_pkg::ADDR_LOW_CNT}:  rdData_reg <= {29'h0, lowCount_reg};
        {1'b0, dmawc_pkg::ADDR_MID_CNT}:  rdData_reg <= {29'h0, midCount_reg};
        dmawc_pkg::ADDR_HIGH_CNT:         rdData_reg <= {29'h0, highCount_reg};
        dmawc_pkg::ADDR_STATUS:
          rdData_reg <= {27'h0, inExtensionState, busStateThree, 1'b0, curArea};
        default:                          rdData_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Area decode
  // ****************************************
  function automatic dmawc_pkg::dmawc_area_t areaOf(input logic [7:0] top,
                                                     input logic [7:0] lowMid,
                                                     input logic [7:0] midHigh);
    dmawc_pkg::dmawc_area_t a;
    a = dmawc_pkg::AREA_LOW;
    if (midHigh != 8'h00 && top >= midHigh) begin
      a = dmawc_pkg::AREA_HIGH;
    end else if (lowMid != 8'h00 && top >= lowMid) begin
      a = dmawc_pkg::AREA_MID;
    end
    return a;
  endfunction

  logic [7:0]                addrTop;
  dmawc_pkg::dmawc_area_t    startArea;
  logic [2:0]                startCount;

  assign addrTop   = dmaReq.addr[ADDR_W-1:dmawc_pkg::BND_LSB];
  assign startArea = areaOf(addrTop, lowMidBoundary_reg, midHighBoundary_reg);

  // Count of the chosen area
  always_comb begin
    unique case (startArea)
      dmawc_pkg::AREA_MID:  startCount = midCount_reg;
      dmawc_pkg::AREA_HIGH: startCount = highCount_reg;
      default:              startCount = lowCount_reg;
    endcase
  end

  // ****************************************
  // Bus-state sequencer
  // ****************************************
  dmawc_pkg::dmawc_state_t   state_reg;
  dmawc_pkg::dmawc_state_t   state_next;
  logic [2:0]                remain_reg;
  logic [2:0]                heldCount_reg;

  // Request line taken in state two or extension; mode selects nothing here
  // since inputs are synchronous to the single rising clock.
  assign extSample = extWaitRequest;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dmawc_pkg::BUS_IDLE: if (dmaReq.start) state_next = dmawc_pkg::BUS_T2;
      dmawc_pkg::BUS_T2,
      dmawc_pkg::BUS_EXT:
        if (remain_reg != 3'h0 || extSample) begin
          state_next = dmawc_pkg::BUS_EXT;
        end else begin
          state_next = dmawc_pkg::BUS_T3;
        end
      dmawc_pkg::BUS_T3:   state_next = dmawc_pkg::BUS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= dmawc_pkg::BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Capture area and count at start; count down on each edge that enters an extension state, from state two or extension
  always_ff @(posedge clock) begin
    if (!nrst) begin
      curArea       <= dmawc_pkg::AREA_LOW;
      remain_reg    <= 3'h0;
      heldCount_reg <= 3'h0;
    end else if (state_reg == dmawc_pkg::BUS_IDLE && dmaReq.start) begin
      curArea       <= startArea;
      remain_reg    <= startCount;
      heldCount_reg <= startCount;
    end else if (state_next == dmawc_pkg::BUS_EXT && remain_reg != 3'h0) begin
      remain_reg    <= remain_reg - 3'h1;
    end
  end

  assign inExtensionState = (state_reg == dmawc_pkg::BUS_EXT);
  assign busStateThree    = (state_reg == dmawc_pkg::BUS_T3);

  // ****************************************
  // Assertions
  // ****************************************
  logic [3:0] extRun;
  always_ff @(posedge clock) begin
    if (!nrst || state_reg == dmawc_pkg::BUS_IDLE) begin
      extRun <= 4'h0;
    end else if (inExtensionState) begin
      extRun <= extRun + 4'h1;
    end
  end

  property p_ext_after_t2;
    @(posedge clock) disable iff (!nrst)
      $rose(inExtensionState) |-> $past(state_reg) == dmawc_pkg::BUS_T2;
  endproperty
  a_ext_after_t2: assert property (p_ext_after_t2) else $error("extension not after T2");

  property p_t3_from_ext_or_t2;
    @(posedge clock) disable iff (!nrst)
      busStateThree |-> $past(state_reg) inside {dmawc_pkg::BUS_T2, dmawc_pkg::BUS_EXT};
  endproperty
  a_t3_from_ext_or_t2: assert property (p_t3_from_ext_or_t2) else $error("bad T3 entry");

  property p_count_min;
    @(posedge clock) disable iff (!nrst)
      busStateThree && !$past(extSample, 2) |-> extRun == {1'b0, heldCount_reg};
  endproperty
  a_count_min: assert property (p_count_min) else $error("wrong extension count");

  property p_ext_holds;
    @(posedge clock) disable iff (!nrst)
      (state_reg inside {dmawc_pkg::BUS_T2, dmawc_pkg::BUS_EXT}) && extSample
        |=> inExtensionState;
  endproperty
  a_ext_holds: assert property (p_ext_holds) else $error("request line ignored");

  property p_area_held;
    @(posedge clock) disable iff (!nrst)
      state_reg != dmawc_pkg::BUS_IDLE |=> $stable(curArea) || $past(busStateThree);
  endproperty
  a_area_held: assert property (p_area_held) else $error("area changed mid-cycle");

  property p_zero_high_absent;
    @(posedge clock) disable iff (!nrst)
      midHighBoundary_reg == 8'h00 |-> startArea != dmawc_pkg::AREA_HIGH;
  endproperty
  a_zero_high_absent: assert property (p_zero_high_absent) else $error("high area with zero");

  property p_high_sel;
    @(posedge clock) disable iff (!nrst)
      midHighBoundary_reg != 8'h00 && addrTop >= midHighBoundary_reg
        |-> startArea == dmawc_pkg::AREA_HIGH;
  endproperty
  a_high_sel: assert property (p_high_sel) else $error("high area not selected");

  property p_low_after_reset;
    @(posedge clock) disable iff (!nrst)
      lowMidBoundary_reg == 8'h00 && midHighBoundary_reg == 8'h00
        |-> startArea == dmawc_pkg::AREA_LOW;
  endproperty
  a_low_after_reset: assert property (p_low_after_reset) else $error("not low area");

  property p_ack_one;
    @(posedge clock) disable iff (!nrst) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

  property p_count_floor;
    @(posedge clock) disable iff (!nrst)
      busStateThree |-> extRun >= {1'b0, heldCount_reg};
  endproperty
  a_count_floor: assert property (p_count_floor) else $error("too few extensions");

  // Register contents on the first edge after reset release
  property p_reset_vals;
    @(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> lowMidBoundary_reg == dmawc_pkg::BND_RESET
        && midHighBoundary_reg == dmawc_pkg::BND_RESET
        && lowCount_reg == dmawc_pkg::CNT_RESET
        && midCount_reg == dmawc_pkg::CNT_RESET
        && highCount_reg == dmawc_pkg::CNT_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_start_t2;
    @(posedge clock) disable iff (!nrst)
      state_reg == dmawc_pkg::BUS_IDLE && dmaReq.start |=> state_reg == dmawc_pkg::BUS_T2;
  endproperty
  a_start_t2: assert property (p_start_t2) else $error("no state two after start");

  property p_t3_one;
    @(posedge clock) disable iff (!nrst)
      busStateThree |=> state_reg == dmawc_pkg::BUS_IDLE;
  endproperty
  a_t3_one: assert property (p_t3_one) else $error("state three too long");

  property p_wr_lands;
    @(posedge clock) disable iff (!nrst)
      wrStrobe && wb_adr_i == {1'b0, dmawc_pkg::ADDR_MID_HIGH}
        |=> midHighBoundary_reg == $past(wb_dat_i[7:0]);
  endproperty
  a_wr_lands: assert property (p_wr_lands) else $error("boundary write lost");

  c_ext_wait:  cover property (@(posedge clock) disable iff (!nrst)
                 busStateThree && $past(extSample));
  c_high_area: cover property (@(posedge clock) disable iff (!nrst)
                 busStateThree && curArea == dmawc_pkg::AREA_HIGH);
  c_zero_wait: cover property (@(posedge clock) disable iff (!nrst)
                 $past(state_reg) == dmawc_pkg::BUS_T2 && busStateThree);
  c_mid_area:  cover property (@(posedge clock) disable iff (!nrst)
                 busStateThree && curArea == dmawc_pkg::AREA_MID);
  c_both_wait: cover property (@(posedge clock) disable iff (!nrst)
                 busStateThree && extRun > {1'b0, heldCount_reg} && heldCount_reg != 3'h0);

endmodule

/* dv/dmawc_wait_model.sv */
module dmawc_wait_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Bench control
  input  wire logic       cycleStart,
  input  wire logic [3:0] holdLen,
  // Request line
  output logic            extWaitRequest
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] holdCnt_reg;
  // Line high for holdLen cycles from bus state two
  always_ff @(posedge clock) begin
    if (!nrst) begin
      holdCnt_reg <= 4'h0;
    end else if (cycleStart) begin
      holdCnt_reg <= holdLen;
    end else if (holdCnt_reg != 4'h0) begin
      holdCnt_reg <= holdCnt_reg - 4'h1;
    end
  end
  assign extWaitRequest = (holdCnt_reg != 4'h0);
endmodule

/* dv/test_dmawc_ctrl.sv */
module test_dmawc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        clock, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic                        cpuModeZero, extWaitRequest, inExtensionState, busStateThree;
  logic [4:0]                  wb_adr_i;
  logic [3:0]                  wb_sel_i, holdLen;
  logic [31:0]                 wb_dat_i, wb_dat_o;
  dmawc_pkg::dmawc_req_t       dmaReq;
  dmawc_pkg::dmawc_area_t      curArea;
  logic [7:0]                  lmB, mhB, v;
  logic [2:0]                  cnt [3];
  logic [31:0]                 expRd[$], expArea[$], expExt[$];
  int                          num_errors, cmp_count, extSeen;
  logic [23:0] bAdr [6] = '{24'h00ffff, 24'h010000, 24'h3fffff, 24'h400000, 24'hffffff, 24'h0};
  // Device and far side
  dmawc_ctrl u_dut (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dmaReq(dmaReq), .cpuModeZero(cpuModeZero),
    .extWaitRequest(extWaitRequest), .inExtensionState(inExtensionState),
    .busStateThree(busStateThree), .curArea(curArea));
  dmawc_wait_model u_wait (.clock(clock), .nrst(nrst), .cycleStart(dmaReq.start),
    .holdLen(holdLen), .extWaitRequest(extWaitRequest));
  // Clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One classic Wishbone cycle, held until ack
  task wb_cycle(input logic we, input logic [4:0] adr, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, s, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin num_errors++; conclude(); end
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task rd(input logic [4:0] adr, input logic [31:0] e);
    expRd.push_back(e);
    wb_cycle(1'b0, adr, 32'h0, 4'hf);
  endtask
  // Write a byte, track it, read it back
  task wr(input logic [4:0] adr, input logic [7:0] d);
    wb_cycle(1'b1, adr, {24'h0, d}, 4'hf);
    if (adr == 5'h00) lmB = d;
    else if (adr == 5'h04) mhB = d;
    else cnt[(adr - 5'h08) >> 2] = d[2:0];
    rd(adr, (adr < 5'h08) ? {24'h0, d} : {29'h0, d[2:0]});
  endtask
  function automatic dmawc_pkg::dmawc_area_t area_of(input logic [23:0] ad);
    if (mhB != 8'h00 && ad[23:16] >= mhB) return dmawc_pkg::AREA_HIGH;
    if (lmB != 8'h00 && ad[23:16] >= lmB) return dmawc_pkg::AREA_MID;
    return dmawc_pkg::AREA_LOW;
  endfunction
  // One DMA cycle; address moves after start to probe capture
  task dma(input logic [23:0] ad, input logic [3:0] len);
    int i;
    dmawc_pkg::dmawc_area_t a;
    a = area_of(ad);
    expArea.push_back({30'h0, a});
    expExt.push_back((len > cnt[a]) ? len : cnt[a]);
    @(posedge clock);
    dmaReq <= '{start: 1'b1, addr: ad};
    holdLen <= len;
    @(posedge clock);
    dmaReq <= '{start: 1'b0, addr: 24'($urandom)};
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      if (busStateThree === 1'b1) break;
    end
    if (i == 40) begin num_errors++; conclude(); end
  endtask
  // Result watcher
  always @(posedge clock) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0)
      check(wb_dat_o, (expRd.size() > 0) ? expRd.pop_front() : 32'hdead);
    if (inExtensionState === 1'b1) extSeen++;
    if (busStateThree === 1'b1) begin
      check({30'h0, curArea}, (expArea.size() > 0) ? expArea.pop_front() : 3);
      check(extSeen, (expExt.size() > 0) ? expExt.pop_front() : 99);
      extSeen = 0;
    end
  end
  // Main sequence
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {cpuModeZero, holdLen, dmaReq, num_errors, cmp_count, extSeen} = '0;
    {lmB, mhB} = 16'h0;
    cnt = '{3'h7, 3'h7, 3'h7};
    void'($urandom(16));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    // Reset values, status and an unmapped place
    for (int k = 0; k < 7; k++) rd(5'(4 * k), (k inside {2, 3, 4}) ? 32'h7 : 32'h0);
    dma(24'($urandom), 4'h0);
    wr(5'h00, 8'h01);
    wr(5'h04, 8'h40);
    for (int k = 0; k < 3; k++) wr(5'(8 + 4 * k), 8'($urandom));
    wb_cycle(1'b1, 5'h00, 32'hff, 4'h0);
    rd(5'h00, 32'h1);
    foreach (bAdr[i]) dma(bAdr[i] | 24'($urandom_range(255)), 4'h0);
    wr(5'h04, 8'h00);
    dma(24'hffffff, 4'h0);
    rd(5'h14, 32'h1);
    wr(5'h08, 8'h02);
    for (int k = 0; k < 5; k++) dma(24'h000100, 4'(k));
    wr(5'h08, 8'h00);
    dma(24'h000200, 4'h0);
    for (int k = 0; k < 12; k++) begin
      v = 8'($urandom_range(255, 1));
      wr(5'h00, v);
      wr(5'h04, (k % 4 == 0) ? 8'h00 : 8'($urandom_range(255, v)));
      for (int j = 0; j < 3; j++) wr(5'(8 + 4 * j), 8'($urandom));
      repeat (3) dma(24'($urandom), 4'($urandom_range(9)));
    end
    repeat (3) @(posedge clock);
    conclude();
  end
  // Hang guard
  initial begin
    #800000;
    num_errors++;
    conclude();
  end
endmodule
